// >>> rtl/tsc_consts.svh
`ifndef TSC_CONSTS_SVH
`define TSC_CONSTS_SVH

// ==========================================================
// widths
`define TSC_AW          9
`define TSC_DW          32
`define TSC_PW          24
`define TSC_SW          8
`define TSC_NSEC        3
`define TSC_LW          4
`define TSC_CNTW        16
`define TSC_PTRW        9
`define TSC_DIVW        16

// ==========================================================
// register byte addresses
`define TSC_REG_CTRL     9'h000
`define TSC_REG_MODE     9'h004
`define TSC_REG_STATUS   9'h008
`define TSC_REG_INT_STAT 9'h00C
`define TSC_REG_INT_MASK 9'h010
`define TSC_REG_PERIOD   9'h014
`define TSC_REG_LIMITS   9'h018
`define TSC_REG_SIG      9'h01C
`define TSC_LVL_SEL_BIT  8
`define TSC_LVL_PAT      2'h0
`define TSC_LVL_DLY      2'h1
`define TSC_LVL_CND      2'h2

// ==========================================================
// field positions
`define TSC_CTRL_START   0
`define TSC_CTRL_HALT    1
`define TSC_MODE_CLK     2:0
`define TSC_MODE_ARM     6:4
`define TSC_MODE_SEL     13:8
`define TSC_LIM_LO       8:0
`define TSC_LIM_HI       24:16
`define TSC_DLY_VAL      15:0
`define TSC_DLY_BYPAT    16
`define TSC_DLY_JMP      23:20
`define TSC_CND_STOP     2:0
`define TSC_CND_JUMP     6:4
`define TSC_CND_ADV      10:8
`define TSC_CND_TRACE    14:12
`define TSC_INT_DONE     0
`define TSC_INT_REARM    1
`define TSC_INT_CMP      2
`define TSC_INTW         3

// ==========================================================
// reset values
`define TSC_PERIOD_RST   16'h0001
`define TSC_LIM_HI_RST   9'h1FF

// ==========================================================
// timing
`define TSC_CLK_MHZ      10
`define TSC_FAST_NS      10
`define TSC_FAST_RAW     ((`TSC_FAST_NS * `TSC_CLK_MHZ) / 1000)
`define TSC_FAST_CYC     ((`TSC_FAST_RAW > 0) ? `TSC_FAST_RAW : 1)

`endif

// >>> rtl/tsc_pkg.sv
package tsc_pkg;
	typedef logic [3:0] tsc_level_t;

	typedef enum logic [2:0] {
		TSC_CLK_INT      = 3'b000,
		TSC_CLK_EXT_ONE  = 3'b001,
		TSC_CLK_EXT_MULT = 3'b010,
		TSC_CLK_MIX_ONE  = 3'b011,
		TSC_CLK_MIX_MULT = 3'b100,
		TSC_CLK_INT_EXT  = 3'b101
	} tsc_clk_mode_e;

	typedef enum logic [2:0] {
		TSC_ARM_MANUAL   = 3'b000,
		TSC_ARM_AUTO     = 3'b001,
		TSC_ARM_EQ       = 3'b010,
		TSC_ARM_NE       = 3'b011,
		TSC_ARM_EQ_LIM   = 3'b100,
		TSC_ARM_NE_LIM   = 3'b101
	} tsc_arm_mode_e;

	typedef enum logic [2:0] {
		TSC_C_MATCH      = 3'b000,
		TSC_C_ALWAYS     = 3'b001,
		TSC_C_NEVER      = 3'b010,
		TSC_C_MATCH_LE   = 3'b011,
		TSC_C_MATCH_GT   = 3'b100
	} tsc_cond_e;

	typedef enum logic [1:0] {
		TSC_SRC_OWN      = 2'b00,
		TSC_SRC_MASTER   = 2'b01,
		TSC_SRC_INT      = 2'b10,
		TSC_SRC_FAST     = 2'b11
	} tsc_src_e;

	typedef enum logic {
		TSC_ST_IDLE      = 1'b0,
		TSC_ST_RUN       = 1'b1
	} tsc_state_e;
endpackage

// >>> rtl/tsc_level_mem.sv
`timescale 1ns/1ps
`include "tsc_consts.svh"

// ==========================================================
// per-level program store, registered read
module tsc_level_mem #(
	parameter int W = `TSC_PW
) (
	input  wire logic                clk,
	input  wire logic                we,
	input  wire logic [`TSC_LW-1:0]  waddr,
	input  wire logic [W-1:0]        wdata,
	input  wire logic [`TSC_LW-1:0]  raddr,
	output logic      [W-1:0]        rdata
);
	logic [W-1:0] mem [0:(1<<`TSC_LW)-1];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // tsc_level_mem

// >>> rtl/tsc_top.sv
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "tsc_consts.svh"

// What this block does
// R1: per-level 16-bit delay, clocks or pattern counts
// R2: trace decision evaluated independently of others
// R3: jump beats advance on same sample
// R4: stop beats jump on same sample
// R5: action codes: 0 match, 1 always, 2 never
// R6: match with count <= delay or > delay
// R7: advance next level, jump target; count restarts
// R8: report level with busy, then ready
// R9: mode 0 internal clock samples everything
// R10: mode 1 master external samples all sections
// R11: mode 2 per-section own or master external
// R12: mode 3 external master; section master/internal/fast
// R13: arm manual, auto, auto-compare with limits
module tsc_top (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic [`TSC_AW-1:0]   addr,
	input  wire logic [`TSC_DW-1:0]   wdata,
	input  wire logic                 wr,
	input  wire logic                 rd,
	output logic      [`TSC_DW-1:0]   rdata,
	output logic                      irq,
	input  wire logic [`TSC_PW-1:0]   probe_data,
	input  wire logic                 ext_clk_master,
	input  wire logic [`TSC_NSEC-1:0] ext_clk_sect,
	output tsc_pkg::tsc_level_t       level,
	output logic                      busy,
	output logic                      ready,
	output logic                      trace_we,
	output logic      [`TSC_PTRW-1:0] trace_addr,
	output logic      [`TSC_PW-1:0]   trace_data
);
	import tsc_pkg::*;

	// ==========================================================
	// helpers
	function automatic logic cond_hit(logic [2:0] c, logic m, logic [`TSC_CNTW-1:0] n,
		logic [`TSC_CNTW-1:0] d);
		case (c)
			TSC_C_MATCH:    cond_hit = m;
			TSC_C_ALWAYS:   cond_hit = 1'b1;
			TSC_C_NEVER:    cond_hit = 1'b0;
			TSC_C_MATCH_LE: cond_hit = m && (n <= d);
			TSC_C_MATCH_GT: cond_hit = m && (n > d);
			default:        cond_hit = 1'b0;
		endcase
	endfunction

	function automatic logic sect_tick(logic [2:0] md, logic [1:0] sel, logic own, logic mst,
		logic itk, logic ftk);
		case (md)
			TSC_CLK_INT:      sect_tick = itk; // R9
			TSC_CLK_EXT_ONE:  sect_tick = mst; // R10
			TSC_CLK_EXT_MULT: sect_tick = (sel == TSC_SRC_OWN) ? own : mst; // R11
			TSC_CLK_MIX_ONE:  sect_tick = (sel == TSC_SRC_INT) ? itk : (sel == TSC_SRC_FAST) ? ftk : mst; // R12
			TSC_CLK_MIX_MULT: sect_tick = (sel == TSC_SRC_OWN) ? own : (sel == TSC_SRC_MASTER) ? mst :
				(sel == TSC_SRC_INT) ? itk : ftk;
			TSC_CLK_INT_EXT:  sect_tick = (sel == TSC_SRC_FAST) ? ftk : itk;
			default:          sect_tick = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// registers
	logic [2:0]            clk_mode, next_clk_mode;
	logic [2:0]            arm_mode, next_arm_mode;
	logic [5:0]            sect_sel, next_sect_sel;
	logic [`TSC_DIVW-1:0]  period, next_period;
	logic [`TSC_PTRW-1:0]  lim_lo, next_lim_lo, lim_hi, next_lim_hi;
	logic [`TSC_INTW-1:0]  int_stat, next_int_stat, int_mask, next_int_mask;
	logic [`TSC_DW-1:0]    next_rdata;
	logic                  next_irq;
	logic                  acc_ctrl, start_req, halt_req, lvl_acc;
	logic                  we_pat, we_dly, we_cnd;
	logic [`TSC_INTW-1:0]  ev;
	logic [`TSC_DW-1:0]    sig, ref_sig;

	assign acc_ctrl  = wr && (addr == `TSC_REG_CTRL);
	assign start_req = acc_ctrl && wdata[`TSC_CTRL_START];
	assign halt_req  = acc_ctrl && wdata[`TSC_CTRL_HALT];
	assign lvl_acc   = wr && addr[`TSC_LVL_SEL_BIT];
	assign we_pat    = lvl_acc && (addr[3:2] == `TSC_LVL_PAT);
	assign we_dly    = lvl_acc && (addr[3:2] == `TSC_LVL_DLY);
	assign we_cnd    = lvl_acc && (addr[3:2] == `TSC_LVL_CND);

	always_comb begin
		next_clk_mode = clk_mode;
		next_arm_mode = arm_mode;
		next_sect_sel = sect_sel;
		next_period   = period;
		next_lim_lo   = lim_lo;
		next_lim_hi   = lim_hi;
		next_int_mask = int_mask;
		next_int_stat = int_stat;
		next_rdata    = '0;
		if (wr) begin
			unique case (addr)
				`TSC_REG_MODE: begin
					next_clk_mode = wdata[`TSC_MODE_CLK];
					next_arm_mode = wdata[`TSC_MODE_ARM]; // R13
					next_sect_sel = wdata[`TSC_MODE_SEL];
				end
				`TSC_REG_INT_STAT: next_int_stat = int_stat & ~wdata[`TSC_INTW-1:0];
				`TSC_REG_INT_MASK: next_int_mask = wdata[`TSC_INTW-1:0];
				`TSC_REG_PERIOD:   next_period   = wdata[`TSC_DIVW-1:0];
				`TSC_REG_LIMITS: begin
					next_lim_lo = wdata[`TSC_LIM_LO];
					next_lim_hi = wdata[`TSC_LIM_HI];
				end
				default: ;
			endcase
		end
		// set wins over a same-cycle clear
		next_int_stat = next_int_stat | ev;
		next_irq = |(next_int_stat & int_mask);
		if (rd) begin
			unique case (addr)
				`TSC_REG_MODE:     next_rdata = {18'h00000, sect_sel, 1'b0, arm_mode, 1'b0, clk_mode};
				`TSC_REG_STATUS:   next_rdata = {26'h0000000, ready, busy, level}; // R8
				`TSC_REG_INT_STAT: next_rdata = {29'h00000000, int_stat};
				`TSC_REG_INT_MASK: next_rdata = {29'h00000000, int_mask};
				`TSC_REG_PERIOD:   next_rdata = {16'h0000, period};
				`TSC_REG_LIMITS:   next_rdata = {7'h00, lim_hi, 7'h00, lim_lo};
				`TSC_REG_SIG:      next_rdata = ref_sig;
				default:           next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			clk_mode <= '0;
			arm_mode <= '0;
			sect_sel <= '0;
			period   <= `TSC_PERIOD_RST;
			lim_lo   <= '0;
			lim_hi   <= `TSC_LIM_HI_RST;
			int_stat <= '0;
			int_mask <= '0;
			rdata    <= '0;
			irq      <= 1'b0;
		end else begin
			clk_mode <= next_clk_mode;
			arm_mode <= next_arm_mode;
			sect_sel <= next_sect_sel;
			period   <= next_period;
			lim_lo   <= next_lim_lo;
			lim_hi   <= next_lim_hi;
			int_stat <= next_int_stat;
			int_mask <= next_int_mask;
			rdata    <= next_rdata;
			irq      <= next_irq;
		end
	end

	// ==========================================================
	// sample clock generation
	// the fast rate cannot beat the system clock, so it floors at one cycle
	logic [`TSC_DIVW-1:0]  div_cnt, next_div_cnt;
	logic [3:0]            fast_cnt, next_fast_cnt;
	logic                  int_tick, fast_tick, mst_edge, mst_tick;
	logic                  mst_prev;
	logic [`TSC_NSEC-1:0]  sect_prev, sect_edge, stick;
	logic [`TSC_PW-1:0]    hold, next_hold, word;

	// a period of zero runs as one instead of wrapping to a 64K-cycle tick
	assign int_tick  = (period == '0) || (div_cnt >= period - `TSC_DIVW'(1));
	assign fast_tick = (fast_cnt == 4'(`TSC_FAST_CYC - 1));
	assign mst_edge  = ext_clk_master && !mst_prev;
	assign sect_edge = ext_clk_sect & ~sect_prev;
	assign mst_tick  = (clk_mode == TSC_CLK_INT || clk_mode == TSC_CLK_INT_EXT) ? int_tick : mst_edge; // R9 R12

	always_comb begin
		next_div_cnt  = int_tick ? '0 : div_cnt + `TSC_DIVW'(1);
		next_fast_cnt = fast_tick ? '0 : fast_cnt + 4'h1;
		next_hold     = hold;
		for (int i = 0; i < `TSC_NSEC; i++) begin
			stick[i] = sect_tick(clk_mode, sect_sel[2*i +: 2], sect_edge[i], mst_edge, int_tick, fast_tick);
			if (stick[i]) begin
				next_hold[i*`TSC_SW +: `TSC_SW] = probe_data[i*`TSC_SW +: `TSC_SW];
			end
		end
		word = next_hold;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_cnt   <= '0;
			fast_cnt  <= '0;
			mst_prev  <= 1'b0;
			sect_prev <= '0;
			hold      <= '0;
		end else begin
			div_cnt   <= next_div_cnt;
			fast_cnt  <= next_fast_cnt;
			mst_prev  <= ext_clk_master;
			sect_prev <= ext_clk_sect;
			hold      <= next_hold;
		end
	end

	// ==========================================================
	// level program store
	logic [`TSC_PW-1:0]    pat;
	logic [23:0]           dly_word;
	logic [15:0]           cnd_word;
	tsc_level_t            next_level;

	tsc_level_mem #(.W(`TSC_PW)) u_pat (.clk(clk), .we(we_pat), .waddr(addr[7:4]),
		.wdata(wdata[`TSC_PW-1:0]), .raddr(next_level), .rdata(pat));
	tsc_level_mem #(.W(24)) u_dly (.clk(clk), .we(we_dly), .waddr(addr[7:4]),
		.wdata(wdata[23:0]), .raddr(next_level), .rdata(dly_word));
	tsc_level_mem #(.W(16)) u_cnd (.clk(clk), .we(we_cnd), .waddr(addr[7:4]),
		.wdata(wdata[15:0]), .raddr(next_level), .rdata(cnd_word));

	// ==========================================================
	// sequencer
	tsc_state_e            st, next_st;
	logic [`TSC_CNTW-1:0]  cnt, next_cnt, dly;
	logic [`TSC_PTRW-1:0]  ptr, next_ptr, next_trace_addr;
	logic [`TSC_DW-1:0]    next_sig, next_ref_sig, sig_upd;
	logic                  have_ref, next_have_ref;
	logic                  next_busy, next_ready, next_trace_we;
	logic [`TSC_PW-1:0]    next_trace_data;
	logic                  match, h_stop, h_jump, h_adv, h_trace, in_lim, same, restart;

	assign dly     = dly_word[`TSC_DLY_VAL]; // R1
	assign match   = (word == pat);
	assign h_stop  = cond_hit(cnd_word[`TSC_CND_STOP], match, cnt, dly); // R5 R6
	assign h_jump  = cond_hit(cnd_word[`TSC_CND_JUMP], match, cnt, dly);
	assign h_adv   = cond_hit(cnd_word[`TSC_CND_ADV], match, cnt, dly);
	assign h_trace = cond_hit(cnd_word[`TSC_CND_TRACE], match, cnt, dly); // R2
	assign in_lim  = (arm_mode != TSC_ARM_EQ_LIM && arm_mode != TSC_ARM_NE_LIM) ||
		(ptr >= lim_lo && ptr <= lim_hi);
	// memory compare is done on a running signature of the traced words
	assign sig_upd = (h_trace && in_lim) ? ({sig[`TSC_DW-2:0], sig[`TSC_DW-1]} ^ {8'h00, word}) : sig;
	assign same    = (sig_upd == ref_sig);

	always_comb begin
		next_st         = st;
		next_level      = level;
		next_cnt        = cnt;
		next_ptr        = ptr;
		next_sig        = sig;
		next_ref_sig    = ref_sig;
		next_have_ref   = have_ref;
		next_busy       = busy;
		next_ready      = ready;
		next_trace_we   = 1'b0;
		next_trace_addr = trace_addr;
		next_trace_data = trace_data;
		ev              = '0;
		restart         = 1'b0;
		if (start_req) begin
			next_st       = TSC_ST_RUN;
			next_have_ref = 1'b0;
			restart       = 1'b1;
		end else if (halt_req) begin
			next_st    = TSC_ST_IDLE;
			next_busy  = 1'b0;
			next_ready = 1'b1;
		end else if (st == TSC_ST_RUN && mst_tick) begin
			if (h_trace) begin // R2
				next_trace_we   = 1'b1;
				next_trace_addr = ptr;
				next_trace_data = word;
				next_ptr        = ptr + `TSC_PTRW'(1);
				next_sig        = sig_upd;
			end
			if (h_stop) begin // R4
				unique case (arm_mode) // R13
					TSC_ARM_AUTO: begin
						restart = 1'b1;
						ev[`TSC_INT_REARM] = 1'b1;
					end
					TSC_ARM_EQ, TSC_ARM_NE, TSC_ARM_EQ_LIM, TSC_ARM_NE_LIM: begin
						if (have_ref && (same == (arm_mode == TSC_ARM_EQ || arm_mode == TSC_ARM_EQ_LIM))) begin
							next_st    = TSC_ST_IDLE;
							next_busy  = 1'b0;
							next_ready = 1'b1;
							ev[`TSC_INT_DONE] = 1'b1;
							ev[`TSC_INT_CMP]  = 1'b1;
						end else begin
							next_ref_sig  = sig_upd;
							next_have_ref = 1'b1;
							restart       = 1'b1;
							ev[`TSC_INT_REARM] = 1'b1;
						end
					end
					default: begin
						next_st    = TSC_ST_IDLE;
						next_busy  = 1'b0;
						next_ready = 1'b1; // R8
						ev[`TSC_INT_DONE] = 1'b1;
					end
				endcase
			end else if (h_jump) begin // R3
				next_level = dly_word[`TSC_DLY_JMP]; // R7
				next_cnt   = '0;
			end else if (h_adv) begin
				next_level = level + 4'h1; // R7
				next_cnt   = '0;
			end else if ((!dly_word[`TSC_DLY_BYPAT] || match) && cnt != '1) begin
				next_cnt = cnt + `TSC_CNTW'(1); // R1
			end
		end
		if (restart) begin
			next_level = '0;
			next_cnt   = '0;
			next_ptr   = '0;
			next_sig   = '0;
			next_busy  = 1'b1; // R8
			next_ready = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st         <= TSC_ST_IDLE;
			level      <= '0;
			cnt        <= '0;
			ptr        <= '0;
			sig        <= '0;
			ref_sig    <= '0;
			have_ref   <= 1'b0;
			busy       <= 1'b0;
			ready      <= 1'b0;
			trace_we   <= 1'b0;
			trace_addr <= '0;
			trace_data <= '0;
		end else begin
			st         <= next_st;
			level      <= next_level;
			cnt        <= next_cnt;
			ptr        <= next_ptr;
			sig        <= next_sig;
			ref_sig    <= next_ref_sig;
			have_ref   <= next_have_ref;
			busy       <= next_busy;
			ready      <= next_ready;
			trace_we   <= next_trace_we;
			trace_addr <= next_trace_addr;
			trace_data <= next_trace_data;
		end
	end
endmodule // tsc_top

// >>> dv/tsc_chk.sv
`timescale 1ns/1ps
`include "tsc_consts.svh"

// ==========================================================
// port checker
module tsc_chk (
	input wire logic                 clk,
	input wire logic                 rst_n,
	input wire logic [`TSC_AW-1:0]   addr,
	input wire logic [`TSC_DW-1:0]   wdata,
	input wire logic                 wr,
	input wire logic                 rd,
	input wire logic [`TSC_DW-1:0]   rdata,
	input wire tsc_pkg::tsc_level_t  level,
	input wire logic                 busy,
	input wire logic                 ready,
	input wire logic                 trace_we
);
	import tsc_pkg::*;
	logic start_wr;
	assign start_wr = wr && addr == `TSC_REG_CTRL && wdata[`TSC_CTRL_START];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	rd_quiet_a: assert property (!rd |=> rdata == '0) else $error("read data outside slot");
	status_read_a: assert property (rd && addr == `TSC_REG_STATUS |=>
		rdata == {26'h0, $past(ready), $past(busy), $past(level)}) else $error("status mismatch");
	start_run_a: assert property (start_wr |=> busy && !ready && level == '0) else $error("start");
	halt_run_a: assert property (wr && addr == `TSC_REG_CTRL && wdata[1:0] == 2'b10 && busy
		|=> !busy && ready) else $error("halt");
	idle_trace_a: assert property (!busy |=> !trace_we) else $error("trace while idle");
	idle_level_a: assert property (!busy && !start_wr |=> $stable(level)) else $error("level moved");
	ready_hold_a: assert property (ready && !start_wr |=> ready) else $error("ready dropped");
	busy_ready_a: assert property (!(busy && ready)) else $error("busy and ready");
endmodule // tsc_chk

bind tsc_top tsc_chk u_chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .level(level), .busy(busy), .ready(ready), .trace_we(trace_we));

// >>> dv/tsc_probe_model.sv
`timescale 1ns/1ps

// ==========================================================
// target bus seen through the probes
module tsc_probe_model (
	input  wire logic        clk,
	output logic      [23:0] probe_data,
	output logic             ext_clk_master,
	output logic      [2:0]  ext_clk_sect
);
	initial begin
		probe_data     = 24'h000000;
		ext_clk_master = 1'b0;
		ext_clk_sect   = 3'h0;
	end
	// one pulse per word; data flips once hold ends so stale values never match
	// ck[3] pulses the master clock, ck[2:0] the section clocks
	task automatic sample_ck(input logic [23:0] w, input logic [3:0] ck);
		@(posedge clk);
		probe_data     <= w;
		ext_clk_master <= ck[3];
		ext_clk_sect   <= ck[2:0];
		@(posedge clk);
		ext_clk_master <= 1'b0;
		ext_clk_sect   <= 3'h0;
		probe_data     <= ~w;
	endtask
	task automatic sample(input logic [23:0] w);
		sample_ck(w, 4'hF);
	endtask
endmodule // tsc_probe_model

// >>> dv/trace_sequence_controller_test.sv
`timescale 1ns/1ps
`include "tsc_consts.svh"

module trace_sequence_controller_test;
	logic               clk, rst_n, wr, rd, irq, busy, ready, trace_we, ext_m;
	logic [8:0]         addr, trace_addr, tr_adr;
	logic [31:0]        wdata, rdata;
	logic [23:0]        probe_data, trace_data, tr_last;
	logic [2:0]         ext_s;
	tsc_pkg::tsc_level_t level;
	int                 num_errors = 0, tests_run = 0, ntr = 0;

	tsc_top u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq(irq), .probe_data(probe_data), .ext_clk_master(ext_m),
		.ext_clk_sect(ext_s), .level(level), .busy(busy), .ready(ready), .trace_we(trace_we),
		.trace_addr(trace_addr), .trace_data(trace_data));
	tsc_probe_model u_probe (.clk(clk), .probe_data(probe_data), .ext_clk_master(ext_m),
		.ext_clk_sect(ext_s));

	// ==========================================================
	// access tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [8:0] a, input logic [31:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask
	task automatic rd_reg(input logic [8:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		v = rdata;
	endtask
	task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd_reg(a, v);
		chk(v, exp);
	endtask
	task automatic lvl(input int l, input logic [31:0] pat, input logic [31:0] dly, input logic [31:0] cnd);
		wr_reg(9'h100 + 9'(l * 16), pat);
		wr_reg(9'h104 + 9'(l * 16), dly);
		wr_reg(9'h108 + 9'(l * 16), cnd);
	endtask
	task automatic go(input logic [31:0] mode);
		wr_reg(`TSC_REG_MODE, mode);
		wr_reg(`TSC_REG_CTRL, 32'h1);
	endtask
	task automatic settle;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic end_of_test;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ==========================================================
	// clock, trace monitor, watchdog
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (trace_we === 1'b1) begin
			ntr++;
			tr_last = trace_data;
			tr_adr  = trace_addr;
		end
	end
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		$display("CHECK FAILED at %0t: watchdog", $time);
		end_of_test();
	end

	// ==========================================================
	// scenarios
	initial begin : main
		logic [31:0] v;
		int          n0, m;
		rst_n = 1'b0;
		addr  = 9'h000;
		wdata = 32'h0;
		wr    = 1'b0;
		rd    = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd_chk(`TSC_REG_STATUS, 32'h0);
		rd_chk(`TSC_REG_PERIOD, 32'h1);
		rd_chk(`TSC_REG_LIMITS, 32'h01FF0000);
		rd_chk(9'h0FC, 32'h0);
		// single-shot trace in each external clock mode, interrupt unmasked
		wr_reg(`TSC_REG_INT_MASK, 32'h1);
		lvl(0, 32'h0, 32'h0, 32'h1221);
		// mode 2: own section clocks, C gets none and keeps the byte of the run before
		// mode 3: A internal, B fast, C master
		for (m = 1; m <= 4; m++) begin
			n0 = ntr;
			v  = 32'hA5C3E1 ^ 32'(m * 32'h010101);
			go((m == 2) ? 32'h0002 : (m == 3) ? 32'h1E03 : 32'h1500 + 32'(m));
			u_probe.sample_ck(v[23:0], (m == 2) ? 4'hB : 4'hF);
			settle();
			chk(32'(ntr - n0), 32'h1);
			chk(tr_last, (m == 2) ? {8'hA4, v[15:0]} : v[23:0]);
			rd_chk(`TSC_REG_STATUS, 32'h20);
			chk(irq, 1'b1);
			wr_reg(`TSC_REG_INT_STAT, 32'h1);
			rd_chk(`TSC_REG_INT_STAT, 32'h0);
			chk(irq, 1'b0);
		end
		// jump over advance, stop over jump, trace never, interrupt masked
		wr_reg(`TSC_REG_INT_MASK, 32'h0);
		lvl(0, 32'hAA, 32'h500000, 32'h2110);
		lvl(5, 32'h55, 32'h300000, 32'h2100);
		n0 = ntr;
		go(32'h1);
		u_probe.sample(24'h000011);
		settle();
		rd_chk(`TSC_REG_STATUS, 32'h15);
		u_probe.sample(24'h000055);
		settle();
		rd_chk(`TSC_REG_STATUS, 32'h25);
		chk(32'(ntr - n0), 32'h0);
		chk(irq, 1'b0);
		rd_chk(`TSC_REG_INT_STAT, 32'h1);
		wr_reg(`TSC_REG_INT_STAT, 32'h7);
		// advance, then stop once count exceeds delay
		lvl(0, 32'h0, 32'h0, 32'h2122);
		lvl(1, 32'hC3, 32'h2, 32'h0224);
		n0 = ntr;
		go(32'h1);
		u_probe.sample(24'h000001);
		for (m = 0; m < 3; m++)
			u_probe.sample(24'h0000C3);
		settle();
		rd_chk(`TSC_REG_STATUS, 32'h11);
		u_probe.sample(24'h0000C3);
		settle();
		rd_chk(`TSC_REG_STATUS, 32'h21);
		chk(32'(ntr - n0), 32'h4);
		chk(32'(tr_adr), 32'h3);
		// count at most delay, halt, count restarts on a new run
		lvl(0, 32'h77, 32'h0, 32'h2223);
		go(32'h1);
		u_probe.sample(24'h000011);
		u_probe.sample(24'h000077);
		settle();
		rd_chk(`TSC_REG_STATUS, 32'h10);
		wr_reg(`TSC_REG_CTRL, 32'h2);
		rd_chk(`TSC_REG_STATUS, 32'h20);
		go(32'h1);
		u_probe.sample(24'h000077);
		settle();
		rd_chk(`TSC_REG_STATUS, 32'h20);
		// internal clock: probes stay quiet, divider alone must tick
		lvl(0, 32'h0, 32'h0, 32'h1221);
		wr_reg(`TSC_REG_PERIOD, 32'h3);
		// mode 0 and mode 5; ready is looked at only once the edge has settled
		for (n0 = 0; n0 <= 5; n0 += 5) begin
			go(32'(n0));
			#1;
			m = 0;
			while (ready !== 1'b1 && m < 20) begin
				@(posedge clk);
				#1;
				m++;
			end
			chk(32'(m >= 1 && m <= 3), 32'h1);
		end
		// automatic rearm keeps running until halted
		go(32'h11);
		u_probe.sample(24'h000042);
		settle();
		rd_reg(`TSC_REG_INT_STAT, v);
		chk(v & 32'h2, 32'h2);
		chk(busy, 1'b1);
		wr_reg(`TSC_REG_CTRL, 32'h2);
		rd_chk(`TSC_REG_STATUS, 32'h20);
		// compare modes: identical runs stop only on the equal forms
		for (m = 2; m <= 5; m++) begin
			go(32'h1 + 32'(m << 4));
			u_probe.sample(24'h000042);
			u_probe.sample(24'h000042);
			settle();
			rd_reg(`TSC_REG_STATUS, v);
			chk(v[5], m == 2 || m == 4);
			wr_reg(`TSC_REG_CTRL, 32'h2);
		end
		end_of_test();
	end
endmodule // trace_sequence_controller_test
